// ### logic/slb_pkg.sv
package slb_pkg;
	// ==========================================
	// Link frame layout
	localparam int FRAME_W      = 36;           // Payload bits 0..35
	localparam int CHECK_LO     = 1;            // First checked payload bit
	localparam int CHECK_HI     = 35;           // Last checked payload bit
	localparam int BC_W         = 8;            // Back-channel frame data bits
	localparam int CRC_W        = 4;            // Back-channel frame check bits
	localparam int ERRCNT_W     = 8;            // Error record width
	localparam logic [22:0] SCR_SEED = 23'h7fffff; // Scrambler start state
	localparam int BC_PERIOD    = 8;            // Clocks per back-channel frame
	localparam int LOCK_CYCLES  = 4;            // Frames before lock declared
	// ==========================================
	// APB register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h04;  // Serializer control
	localparam logic [7:0] REG_STATUS = 8'h0c;  // Serializer link status
	localparam logic [7:0] REG_ERRCNT = 8'h10;  // Self-test error record
	localparam logic [7:0] REG_IRQST  = 8'h14;  // Sticky events
	localparam logic [7:0] REG_IRQMSK = 8'h18;  // Event mask
	localparam logic [7:0] REG_DCTRL  = 8'h20;  // Deserializer control
	localparam logic [7:0] REG_DSTAT  = 8'h24;  // Deserializer status
	// Field positions
	localparam int CTRL_SELFTEST  = 5;          // Local self-test toggle bit
	localparam int STAT_LINKDET   = 0;          // Back-channel link detect
	localparam int STAT_INTEST    = 1;          // Self test running
	localparam int STAT_ARMED     = 2;          // Self-test bit written, clear write pending
	localparam int DCTRL_ENABLE   = 0;          // Register start of test
	localparam int DCTRL_CLKSEL   = 1;          // Register oscillator select
	localparam int DSTAT_PASS     = 0;
	localparam int DSTAT_LOCK     = 1;
	localparam int DSTAT_INTEST   = 2;
	localparam int DSTAT_USEOSC   = 3;
	localparam int IRQ_W          = 3;
	localparam int IRQ_START      = 0;          // Test entered
	localparam int IRQ_STOP       = 1;          // Test left
	localparam int IRQ_ERR        = 2;          // Error seen
	localparam logic [31:0] RST_VAL = 32'h0000_0000;
	// Back-channel frame bit carrying the test request
	localparam int BC_TESTBIT     = 0;
	localparam int BC_CLKBIT      = 1;
endpackage

// ### logic/slb_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Forward serial frames and back-channel frames between both ends
interface slb_link_if;
	logic [35:0] fwd_frame;   // Scrambled forward payload
	logic        fwd_valid;   // Forward frame strobe
	logic        fwd_testmode; // Serializer runs the test pattern
	logic [7:0]  bc_data;     // Back-channel frame data
	logic [3:0]  bc_crc;      // Back-channel frame check field
	logic        bc_valid;    // Back-channel frame strobe
	modport ser (output fwd_frame, output fwd_valid, output fwd_testmode,
		input bc_data, input bc_crc, input bc_valid);
	modport des (input fwd_frame, input fwd_valid, input fwd_testmode,
		output bc_data, output bc_crc, output bc_valid);
endinterface
`default_nettype wire

// ### logic/slb_apb_regs.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Small APB slave: one control word, read mux, read-clear events
module slb_apb_regs (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  ctrl_addr,
	input  wire logic [31:0] ro_a,
	input  wire logic [7:0]  ro_a_addr,
	input  wire logic [31:0] ro_b,
	input  wire logic [7:0]  ro_b_addr,
	input  wire logic [2:0]  events,
	input  wire logic [7:0]  irqst_addr,
	input  wire logic [7:0]  irqmsk_addr,
	output logic      [31:0] ctrl,
	output logic             wr_ctrl,
	output logic             irq
);
	logic        access;
	logic [31:0] next_ctrl;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic [2:0]  irq_st;
	logic [2:0]  next_irq_st;
	logic [2:0]  irq_msk;
	logic [2:0]  next_irq_msk;
	logic        rd_st;

	// Access phase; slave answers with one wait state, pready in the second access cycle
	assign access  = psel & penable & ~pready;
	assign wr_ctrl = access & pwrite & (paddr == ctrl_addr);
	assign rd_st   = access & ~pwrite & (paddr == irqst_addr);

	// Next register values and read data
	always_comb begin
		next_ctrl    = wr_ctrl ? pwdata : ctrl;
		next_irq_msk = (access & pwrite & (paddr == irqmsk_addr)) ? pwdata[2:0] : irq_msk;
		next_irq_st  = (rd_st ? 3'h0 : irq_st) | events; // New event wins over read clear
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (paddr == ctrl_addr)
			next_prdata = ctrl;
		else if (paddr == ro_a_addr)
			next_prdata = ro_a;
		else if (paddr == ro_b_addr)
			next_prdata = ro_b;
		else if (paddr == irqst_addr)
			next_prdata = {29'h0, irq_st};
		else if (paddr == irqmsk_addr)
			next_prdata = {29'h0, irq_msk};
		else
			next_pslverr = 1'b1;
	end

	// Register stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl    <= 32'h0000_0000;
			irq_st  <= 3'h0;
			irq_msk <= 3'h0;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			irq     <= 1'b0;
		end else if (clk_en) begin
			ctrl    <= next_ctrl;
			irq_st  <= next_irq_st;
			irq_msk <= next_irq_msk;
			prdata  <= access ? next_prdata : 32'h0000_0000;
			pready  <= access;
			pslverr <= access & next_pslverr;
			irq     <= |(next_irq_st & next_irq_msk);
		end
	end
endmodule
`default_nettype wire

// ### logic/slb_serializer.sv
`timescale 1ns/10ps
`default_nettype none
module slb_serializer (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic [35:0] video_in,
	output logic             in_selftest,
	slb_link_if.ser          link
);
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT_SET, ST_WAIT_CLR, ST_RUN} slb_ser_state_e;

	slb_ser_state_e         state;
	slb_ser_state_e         next_state;
	logic [35:0]            video_q;
	logic [35:0]            next_video_q;
	logic [22:0]            scr;
	logic [22:0]            next_scr;
	logic                   disparity;
	logic                   next_disparity;
	logic [35:0]            next_frame;
	logic                   next_valid;
	logic [slb_pkg::ERRCNT_W-1:0] err_cnt;
	logic [slb_pkg::ERRCNT_W-1:0] next_err_cnt;
	logic [2:0]             lock_cnt;
	logic [2:0]             next_lock_cnt;
	logic                   link_det;
	logic                   next_in_selftest;
	logic                   req;
	logic                   crc_bad;
	logic [3:0]             crc_calc;
	logic [31:0]            ctrl;
	logic                   wr_ctrl;
	logic [2:0]             events;
	logic [35:0]            payload;
	logic [35:0]            scrambled;
	logic [31:0]            status_word;
	logic [31:0]            err_word;

	// ==========================================
	// Back-channel decode
	assign req = link.bc_data[slb_pkg::BC_TESTBIT];
	always_comb begin
		crc_calc = {^link.bc_data[7:6], ^link.bc_data[5:4], ^link.bc_data[3:2], ^link.bc_data[1:0]};
	end
	assign crc_bad  = link.bc_valid & (crc_calc != link.bc_crc);
	assign link_det = (lock_cnt == 3'(slb_pkg::LOCK_CYCLES));

	// ==========================================
	// Start sequence and test state
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE:     if (link.bc_valid & req & link_det) next_state = ST_WAIT_SET;
			ST_WAIT_SET: if (wr_ctrl & pwdata[slb_pkg::CTRL_SELFTEST]) next_state = ST_WAIT_CLR;
			ST_WAIT_CLR: if (wr_ctrl & ~pwdata[slb_pkg::CTRL_SELFTEST]) next_state = ST_RUN;
			ST_RUN:      ;
		endcase
		if (state != ST_IDLE && link.bc_valid && !req)
			next_state = ST_IDLE;
		next_in_selftest = (next_state == ST_RUN);
	end

	// ==========================================
	// Error record and back-channel lock
	always_comb begin
		next_err_cnt  = err_cnt;
		next_lock_cnt = lock_cnt;
		if (link.bc_valid) begin
			if (crc_bad)
				next_lock_cnt = 3'h0;
			else if (!link_det)
				next_lock_cnt = lock_cnt + 3'h1;
		end
		if (next_in_selftest & ~in_selftest)
			next_err_cnt = '0;
		else if (in_selftest & link_det & crc_bad & (err_cnt != '1))
			next_err_cnt = err_cnt + 8'h01;
	end

	// ==========================================
	// Forward stream: zeros or video, scrambled and balanced
	assign payload = in_selftest ? 36'h0 : video_q;
	always_comb begin
		next_scr = scr;
		for (int i = 0; i < 36; i++) begin
			scrambled[i] = payload[i] ^ next_scr[22] ^ next_scr[17];
			next_scr     = {next_scr[21:0], next_scr[22] ^ next_scr[17]};
		end
		next_disparity = disparity;
		next_frame     = scrambled;
		if ((^scrambled) == disparity)
			next_frame = ~scrambled;
		next_disparity = ~disparity;
		next_video_q   = video_in;
		next_valid     = 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state          <= ST_IDLE;
			in_selftest    <= 1'b0;
			err_cnt        <= '0;
			lock_cnt       <= 3'h0;
			scr            <= slb_pkg::SCR_SEED;
			disparity      <= 1'b0;
			video_q        <= 36'h0;
			link.fwd_frame <= 36'h0;
			link.fwd_valid <= 1'b0;
			link.fwd_testmode <= 1'b0;
		end else if (clk_en) begin
			state          <= next_state;
			in_selftest    <= next_in_selftest;
			err_cnt        <= next_err_cnt;
			lock_cnt       <= next_lock_cnt;
			scr            <= next_scr;
			disparity      <= next_disparity;
			video_q        <= next_video_q;
			link.fwd_frame <= next_frame;
			link.fwd_valid <= next_valid;
			link.fwd_testmode <= next_in_selftest;
		end
	end

	// ==========================================
	// Register access
	assign status_word = {29'h0, (state == ST_WAIT_CLR), in_selftest, link_det};
	assign err_word    = {24'h0, err_cnt};
	assign events      = {in_selftest & link_det & crc_bad,
		~next_in_selftest & in_selftest, next_in_selftest & ~in_selftest};

	slb_apb_regs u_regs (
		.clk         (clk),
		.arst_n      (arst_n),
		.clk_en      (clk_en),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.ctrl_addr   (slb_pkg::REG_CTRL),
		.ro_a        (status_word),
		.ro_a_addr   (slb_pkg::REG_STATUS),
		.ro_b        (err_word),
		.ro_b_addr   (slb_pkg::REG_ERRCNT),
		.events      (events),
		.irqst_addr  (slb_pkg::REG_IRQST),
		.irqmsk_addr (slb_pkg::REG_IRQMSK),
		.ctrl        (ctrl),
		.wr_ctrl     (wr_ctrl),
		.irq         (irq)
	);
endmodule
`default_nettype wire

// ### logic/slb_deserializer.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Far end: starts the test, checks the stream, drives pass
module slb_deserializer (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	input  wire logic        selftest_enable_pin,
	input  wire logic        selftest_clock_select_pin,
	input  wire logic        pixel_clock_present,
	input  wire logic        cfg_enable,
	input  wire logic        cfg_clock_select,
	output logic             pass,
	output logic             lock,
	output logic             use_oscillator,
	output logic             in_selftest,
	slb_link_if.des          link
);
	logic [1:0]  en_sync;
	logic [1:0]  cs_sync;
	logic [1:0]  pc_sync;
	logic        active;
	logic [2:0]  bc_cnt;
	logic [2:0]  next_bc_cnt;
	logic [7:0]  next_bc_data;
	logic        next_pass;
	logic        next_lock;
	logic        checking;
	logic        next_checking;
	logic        frame_err;
	logic [22:0] scr;
	logic [22:0] next_scr;
	logic        disparity;
	logic [35:0] key;
	logic [35:0] exp_frame;
	logic [35:0] next_exp_frame;

	// Pin synchronisers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			en_sync <= 2'h0;
			cs_sync <= 2'h0;
			pc_sync <= 2'h0;
		end else if (clk_en) begin
			en_sync <= {en_sync[0], selftest_enable_pin};
			cs_sync <= {cs_sync[0], selftest_clock_select_pin};
			pc_sync <= {pc_sync[0], pixel_clock_present};
		end
	end

	assign active = en_sync[1] | cfg_enable;
	// Local scrambler replica in lockstep; expected frame is a scrambled, balanced zero payload
	always_comb begin
		next_scr = scr;
		for (int i = 0; i < 36; i++) begin
			key[i]   = next_scr[22] ^ next_scr[17];
			next_scr = {next_scr[21:0], next_scr[22] ^ next_scr[17]};
		end
		next_exp_frame = key;
		if ((^key) == disparity)
			next_exp_frame = ~key;
	end

	// Any mismatch in bits 1..35 against the expected zero frame is an error
	assign frame_err = link.fwd_valid & link.fwd_testmode & (link.fwd_frame[35:1] != exp_frame[35:1]);

	// Replica state, frozen with the serializer by the shared enable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scr       <= slb_pkg::SCR_SEED;
			disparity <= 1'b0;
			exp_frame <= 36'h0;
		end else if (clk_en) begin
			scr       <= next_scr;
			disparity <= ~disparity;
			exp_frame <= next_exp_frame;
		end
	end

	// Back-channel frames, pass and lock
	always_comb begin
		next_bc_cnt   = (bc_cnt == 3'(slb_pkg::BC_PERIOD - 1)) ? 3'h0 : bc_cnt + 3'h1;
		next_bc_data  = 8'h00;
		next_bc_data[slb_pkg::BC_TESTBIT] = active;
		next_bc_data[slb_pkg::BC_CLKBIT]  = cs_sync[1] | cfg_clock_select | ~pc_sync[1];
		next_lock     = lock | link.fwd_valid;
		next_checking = active & link.fwd_testmode & next_lock;
		next_pass     = pass;
		if (next_checking & ~checking)
			next_pass = 1'b1;
		else if (checking & frame_err)
			next_pass = 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bc_cnt         <= 3'h0;
			link.bc_data   <= 8'h00;
			link.bc_crc    <= 4'h0;
			link.bc_valid  <= 1'b0;
			pass           <= 1'b0;
			lock           <= 1'b0;
			checking       <= 1'b0;
			in_selftest    <= 1'b0;
			use_oscillator <= 1'b0;
		end else if (clk_en) begin
			bc_cnt         <= next_bc_cnt;
			link.bc_valid  <= (bc_cnt == 3'h0);
			link.bc_data   <= next_bc_data;
			link.bc_crc    <= {^next_bc_data[7:6], ^next_bc_data[5:4], ^next_bc_data[3:2], ^next_bc_data[1:0]};
			pass           <= next_pass;
			lock           <= next_lock;
			checking       <= next_checking;
			in_selftest    <= active;
			use_oscillator <= next_bc_data[slb_pkg::BC_CLKBIT];
		end
	end
endmodule
`default_nettype wire

// ### dv/slb_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Link checker between serializer and deserializer
module slb_link_sva (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [35:0] fwd_frame,
	input wire logic        fwd_valid,
	input wire logic        fwd_testmode,
	input wire logic [7:0]  bc_data,
	input wire logic        bc_valid
);
	logic last_req;

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Request bit of the latest back-channel frame
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			last_req <= 1'b0;
		end else if (bc_valid) begin
			last_req <= bc_data[slb_pkg::BC_TESTBIT];
		end
	end

	// ==========================================
	// Properties
	property p_rise_needs_req;
		$rose(fwd_testmode) |-> last_req;
	endproperty
	a_rise_needs_req: assert property (p_rise_needs_req) else $error("test mode without request");
	property p_fall_needs_drop;
		$fell(fwd_testmode) |-> !last_req;
	endproperty
	a_fall_needs_drop: assert property (p_fall_needs_drop) else $error("test left while requested");
	property p_drop_ends_test;
		bc_valid && !bc_data[slb_pkg::BC_TESTBIT] && fwd_testmode |-> ##[1:4] !fwd_testmode;
	endproperty
	a_drop_ends_test: assert property (p_drop_ends_test) else $error("test not left after drop");
	property p_full_speed;
		fwd_testmode |-> fwd_valid;
	endproperty
	a_full_speed: assert property (p_full_speed) else $error("forward frame missing in test");
	property p_nonzero_payload;
		fwd_testmode && fwd_valid |-> fwd_frame != 36'h0;
	endproperty
	a_nonzero_payload: assert property (p_nonzero_payload) else $error("payload left unscrambled");
	property p_payload_moves;
		fwd_testmode && $past(fwd_testmode) |-> fwd_frame != $past(fwd_frame);
	endproperty
	a_payload_moves: assert property (p_payload_moves) else $error("scrambler stalled");
	property p_bc_gap;
		bc_valid |=> !bc_valid [*7];
	endproperty
	a_bc_gap: assert property (p_bc_gap) else $error("back-channel frame too soon");
	property p_bc_period;
		bc_valid |-> ##8 bc_valid;
	endproperty
	a_bc_period: assert property (p_bc_period) else $error("back-channel frame missing");
endmodule
`default_nettype wire

// ### dv/serial_link_at_speed_selftest_serializer_test.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Both link ends, plus a second serializer fed corrupted frames
module serial_link_at_speed_selftest_serializer_test;
	logic        clk, arst_n, en, psel_a, psel_b, penable, pwrite, corrupt;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata_a, prdata_b, rd;
	logic        pready_a, pready_b, pslverr_a, pslverr_b, irq_a, irq_b, err;
	logic [35:0] video_in;
	logic        ins_a, ins_b, pin_en, pin_sel, pix, cfg_en, cfg_sel;
	logic        pass, lock, use_osc, des_ins;
	int          fails, checks_done, n;
	logic [2:0]  osc_tab [4] = '{3'b100, 3'b000, 3'b110, 3'b101};

	slb_link_if link();
	slb_link_if link2();
	// Fault link: copy of the real back channel, check field flipped on demand
	assign link2.bc_data  = link.bc_data;
	assign link2.bc_valid = link.bc_valid;
	assign link2.bc_crc   = link.bc_crc ^ {4{corrupt}};

	slb_serializer slb_serializer_i (.clk(clk), .arst_n(arst_n), .clk_en(en), .psel(psel_a), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_a), .pready(pready_a),
		.pslverr(pslverr_a), .irq(irq_a), .video_in(video_in), .in_selftest(ins_a), .link(link));
	slb_serializer slb_serializer_i_fault (.clk(clk), .arst_n(arst_n), .clk_en(en), .psel(psel_b),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_b),
		.pready(pready_b), .pslverr(pslverr_b), .irq(irq_b), .video_in(video_in), .in_selftest(ins_b),
		.link(link2));
	slb_deserializer slb_deserializer_i (.clk(clk), .arst_n(arst_n), .clk_en(en), .selftest_enable_pin(pin_en),
		.selftest_clock_select_pin(pin_sel), .pixel_clock_present(pix), .cfg_enable(cfg_en),
		.cfg_clock_select(cfg_sel), .pass(pass), .lock(lock), .use_oscillator(use_osc),
		.in_selftest(des_ins), .link(link));
	slb_link_sva slb_link_sva_i (.clk(clk), .arst_n(arst_n), .fwd_frame(link.fwd_frame),
		.fwd_valid(link.fwd_valid), .fwd_testmode(link.fwd_testmode), .bc_data(link.bc_data),
		.bc_valid(link.bc_valid));

	// ==========================================
	// Shared tasks
	task check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, seen);
			fails++;
		end
	endtask
	task apb(input logic s2, input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel_a  <= !s2;
		psel_b  <= s2;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while ((s2 ? pready_b : pready_a) !== 1'b1 && k < 50);
		if (k >= 50)
			fails++;
		rd  = s2 ? prdata_b : prdata_a;
		err = s2 ? pslverr_b : pslverr_a;
		psel_a  <= 1'b0;
		psel_b  <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Local start sequence on both serializers
	task toggle();
		apb(1'b0, 1'b1, slb_pkg::REG_CTRL, 32'h0000_0020);
		apb(1'b1, 1'b1, slb_pkg::REG_CTRL, 32'h0000_0020);
		check("test before clear", ins_a, 1'b0);
		apb(1'b0, 1'b1, slb_pkg::REG_CTRL, 32'h0000_0000);
		apb(1'b1, 1'b1, slb_pkg::REG_CTRL, 32'h0000_0000);
	endtask
	// cnt times: one corrupted frame, then enough clean frames to regain link detect
	task bad_frames(input int cnt);
		repeat (cnt) begin
			@(posedge clk iff link.bc_valid);
			corrupt <= 1'b1;
			@(posedge clk iff link.bc_valid);
			corrupt <= 1'b0;
			repeat (slb_pkg::LOCK_CYCLES) @(posedge clk iff link.bc_valid);
		end
	endtask

	// ==========================================
	// Scenarios
	task t_reset();
		check("pass at reset", pass, 1'b0);
		apb(1'b0, 1'b0, slb_pkg::REG_ERRCNT, 32'h0);
		check("errcnt at reset", rd, 32'h0);
		apb(1'b0, 1'b0, 8'h3c, 32'h0);
		check("unmapped error", err, 1'b1);
		check("unmapped data", rd, 32'h0);
	endtask
	task t_clock_select();
		foreach (osc_tab[i]) begin
			{pix, pin_sel, cfg_sel} <= osc_tab[i];
			repeat (5) @(posedge clk);
			check("oscillator select", use_osc, !osc_tab[i][2] | osc_tab[i][1] | osc_tab[i][0]);
		end
		{pix, pin_sel, cfg_sel} <= 3'b100;
	endtask
	task t_clean_run();
		video_in <= 36'hf_ffff_ffff;
		apb(1'b0, 1'b0, slb_pkg::REG_STATUS, 32'h0);
		check("link detect", rd[slb_pkg::STAT_LINKDET], 1'b1);
		pin_en <= 1'b1;
		repeat (40) @(posedge clk);
		check("test before toggle", ins_a, 1'b0);
		toggle();
		check("serializer in test", ins_a, 1'b1);
		for (n = 0; n < 300 && pass !== 1'b1; n++) @(posedge clk);
		repeat (200) @(posedge clk);
		check("pass in clean run", pass, 1'b1);
		check("lock in test", lock, 1'b1);
		pin_en <= 1'b0;
		repeat (40) @(posedge clk);
		check("serializer left test", ins_a, 1'b0);
		check("deserializer left test", des_ins, 1'b0);
		check("pass held high", pass, 1'b1);
		apb(1'b0, 1'b0, slb_pkg::REG_IRQST, 32'h0);
		check("start and stop events", rd[2:0], 3'b011);
	endtask
	task t_errors();
		corrupt <= 1'b1;
		repeat (40) @(posedge clk);
		corrupt <= 1'b0;
		apb(1'b1, 1'b0, slb_pkg::REG_ERRCNT, 32'h0);
		check("no count outside test", rd, 32'h0);
		apb(1'b1, 1'b0, slb_pkg::REG_IRQST, 32'h0);
		cfg_en <= 1'b1;
		repeat (40) @(posedge clk);
		toggle();
		check("register start", ins_b, 1'b1);
		bad_frames(5);
		apb(1'b1, 1'b0, slb_pkg::REG_ERRCNT, 32'h0);
		check("crc error count", rd, 32'h5);
		check("irq masked", irq_b, 1'b0);
		apb(1'b1, 1'b1, slb_pkg::REG_IRQMSK, 32'h0000_0004);
		check("irq unmasked", irq_b, 1'b1);
		bad_frames(260);
		apb(1'b1, 1'b0, slb_pkg::REG_ERRCNT, 32'h0);
		check("count saturates", rd, 32'hff);
		cfg_en <= 1'b0;
		repeat (40) @(posedge clk);
		apb(1'b1, 1'b0, slb_pkg::REG_ERRCNT, 32'h0);
		check("count kept after test", rd, 32'hff);
		apb(1'b1, 1'b0, slb_pkg::REG_IRQST, 32'h0);
		check("all events", rd[2:0], 3'b111);
		check("irq cleared by read", irq_b, 1'b0);
		cfg_en <= 1'b1;
		repeat (40) @(posedge clk);
		toggle();
		apb(1'b1, 1'b0, slb_pkg::REG_ERRCNT, 32'h0);
		check("count cleared on entry", rd, 32'h0);
		cfg_en <= 1'b0;
	endtask
	task end_of_test();
		if (fails == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========================================
	// Clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		end_of_test();
	end
	initial begin
		{arst_n, en, psel_a, psel_b, penable, pwrite, corrupt} = 7'b0100000;
		{pin_en, pin_sel, pix, cfg_en, cfg_sel} = 5'b00100;
		{paddr, pwdata, video_in} = '0;
		fails = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (60) @(posedge clk);
		t_reset();
		t_clock_select();
		t_clean_run();
		t_errors();
		end_of_test();
	end
endmodule
`default_nettype wire
